// file: hdl/mii_port_cfg.svh
/*
  Constants for the second MII packet port: clock rates, nibble width,
  frame layout on the transmit side and LED stretch times.
  Assumes it is included by the package and the port modules by bare name.
*/
`ifndef MII_PORT_CFG_SVH
`define MII_PORT_CFG_SVH

`define NIBBLE_W           4
`define CORE_CLK_HZ        10000000
`define LINK_CLK_HZ        25000000
`define PREAMBLE_NIBBLES   4'hf
`define SFD_NIBBLE         4'hd
`define PREAMBLE_NIBBLE    4'h5
`define FALSE_CARRIER_CODE 4'he
`define ACT_HOLD_MS        10
`define ACT_HOLD_CYCLES    ((`ACT_HOLD_MS * `CORE_CLK_HZ) / 1000)
`define ACT_CNT_W          20

`endif

// file: hdl/mii_port_pkg.sv
/*
  Types shared by the second MII packet port.
  Assumes the constants header is reachable on the include path.
*/
`default_nettype none
`include "mii_port_cfg.svh"

package mii_port_pkg;
  typedef logic [`NIBBLE_W-1:0] nibble_t;
  typedef enum logic [1:0] {TX_IDLE, TX_PREAMBLE, TX_DATA} tx_state_t;
endpackage

`default_nettype wire

// file: hdl/sync_two_ff.sv
/*
  Two flip-flop synchroniser for one level signal.
  Assumes the input is a level held for at least two destination clocks.
*/
`default_nettype none

module sync_two_ff
(
  input  wire logic clk_i,    // Destination clock.
  input  wire logic resetn_i, // Synchronous reset, active low.
  input  wire logic async_i,  // Level from another domain.
  output logic      sync_o    // Level safe to read in this domain.
);

  logic meta;

  always_ff @(posedge clk_i)
  begin
    if (!resetn_i)
    begin
      meta   <= 1'b0;
      sync_o <= 1'b0;
    end
    else
    begin
      meta   <= async_i;
      sync_o <= meta;
    end
  end

endmodule // sync_two_ff

`default_nettype wire

// file: hdl/mii_port.sv
/*
  Second packet port: 4-bit MII link to an external PHY at 100 Mbps.
  The receive logic runs on the PHY receive clock, the transmit logic on
  the PHY transmit clock, and LED and status logic on the core clock.
  Assumes both PHY clocks are 25 MHz and the core clock is 10 MHz.
*/
// What this block does
// - Receive nibble captured each receive clock rise.
// - Receive-error counts as frame error when valid.
// - Error without valid, on nibble 4'he, means false carrier.
// - Collision used only in half duplex.
// - Carrier-sense asynchronous; synchronise before use.
// - Transmit-enable spans preamble through last nibble.
// - Transmit-error with enable corrupts frame.
// - Transmit nibble updates on transmit clock rise.
// - LEDs low for link up and activity.
`default_nettype none
`include "mii_port_cfg.svh"

module mii_port
  import mii_port_pkg::*;
(
  input  wire logic                 clk_i,              // Core clock.
  input  wire logic                 resetn_i,           // Core reset, low.
  input  wire logic                 port_rx_clock,      // PHY receive clock.
  input  wire logic                 port_tx_clock,      // PHY transmit clock.
  input  wire logic                 rx_resetn_i,        // Rx reset, low.
  input  wire logic                 tx_resetn_i,        // Tx reset, low.
  input  wire mii_port_pkg::nibble_t port_rx_nibble,    // Receive nibble.
  input  wire logic                 port_rx_valid,      // Receive valid.
  input  wire logic                 port_rx_error,      // Receive error.
  input  wire logic                 port_collision_in,  // Collision, async.
  input  wire logic                 port_carrier_sense, // Carrier, async.
  output logic                      port_tx_enable,     // Transmit enable.
  output logic                      port_tx_error,      // Transmit error.
  output mii_port_pkg::nibble_t     port_tx_nibble,     // Transmit nibble.
  output logic                      port_link_led_n,    // Link LED, low on.
  output logic                      port_activity_led_n,// Activity LED.
  input  wire logic                 link_up_i,          // Link status, core.
  input  wire logic                 half_duplex_i,      // Half duplex mode.
  input  wire logic                 tx_valid_i,         // Tx data offered.
  input  wire mii_port_pkg::nibble_t tx_data_i,         // Tx data nibble.
  input  wire logic                 tx_last_i,          // Last data nibble.
  input  wire logic                 tx_corrupt_i,       // Corrupt this nibble.
  output logic                      tx_ready_o,         // Tx nibble taken.
  output logic                      tx_abort_o,         // Collision abort.
  output logic                      rx_valid_o,         // Rx data valid.
  output mii_port_pkg::nibble_t     rx_data_o,          // Rx data nibble.
  output logic                      rx_frame_err_o,     // Rx frame error.
  output logic                      rx_false_carrier_o, // False carrier seen.
  output logic                      carrier_o           // Carrier, core clock.
);

  //////////////////////////////////////////////////////////////////////////////
  // Receive side, on the PHY receive clock.

  nibble_t rx_nib_q;
  logic    rx_dv_q;
  logic    rx_er_q;
  logic    rx_act_tgl;

  always_ff @(posedge port_rx_clock)
  begin
    if (!rx_resetn_i)
    begin
      rx_nib_q <= 4'h0;
      rx_dv_q  <= 1'b0;
      rx_er_q  <= 1'b0;
    end
    else
    begin
      rx_nib_q <= port_rx_nibble;
      rx_dv_q  <= port_rx_valid;
      rx_er_q  <= port_rx_error;
    end
  end

  always_ff @(posedge port_rx_clock)
  begin
    if (!rx_resetn_i)
    begin
      rx_valid_o         <= 1'b0;
      rx_data_o          <= 4'h0;
      rx_frame_err_o     <= 1'b0;
      rx_false_carrier_o <= 1'b0;
    end
    else
    begin
      rx_valid_o     <= rx_dv_q;
      rx_data_o      <= rx_nib_q;
      rx_frame_err_o <= rx_dv_q && rx_er_q;
      rx_false_carrier_o <= !rx_dv_q && rx_er_q
                            && (rx_nib_q == `FALSE_CARRIER_CODE);
    end
  end

  // One toggle per received nibble keeps the activity event crossable
  // even though the receive clock is faster than the core clock.
  always_ff @(posedge port_rx_clock)
  begin
    if (!rx_resetn_i)
      rx_act_tgl <= 1'b0;
    else if (rx_dv_q)
      rx_act_tgl <= ~rx_act_tgl;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Transmit side, on the PHY transmit clock.

  logic      col_tx;
  logic      crs_tx;
  tx_state_t state;
  logic [3:0] pre_cnt;
  logic      tx_act_tgl;

  sync_two_ff u_col_sync
  (
    .clk_i    (port_tx_clock),
    .resetn_i (tx_resetn_i),
    .async_i  (port_collision_in),
    .sync_o   (col_tx)
  );

  sync_two_ff u_crs_sync
  (
    .clk_i    (port_tx_clock),
    .resetn_i (tx_resetn_i),
    .async_i  (port_carrier_sense),
    .sync_o   (crs_tx)
  );

  logic abort;
  assign abort = col_tx && half_duplex_i && (state != TX_IDLE);
  assign tx_abort_o = abort;
  assign tx_ready_o = (state == TX_DATA) && tx_valid_i && !abort;

  // In half duplex a busy carrier defers the start of a new frame.
  always_ff @(posedge port_tx_clock)
  begin
    if (!tx_resetn_i)
    begin
      state   <= TX_IDLE;
      pre_cnt <= 4'h0;
    end
    else
    begin
      case (state)
        TX_IDLE:
          if (tx_valid_i && !(half_duplex_i && crs_tx))
          begin
            state   <= TX_PREAMBLE;
            pre_cnt <= 4'h0;
          end
        TX_PREAMBLE:
          if (abort)
            state <= TX_IDLE;
          else if (pre_cnt == `PREAMBLE_NIBBLES)
            state <= TX_DATA;
          else
            pre_cnt <= pre_cnt + 4'h1;
        TX_DATA:
          if (abort || (tx_valid_i && tx_last_i))
            state <= TX_IDLE;
        default:
          state <= TX_IDLE;
      endcase
    end
  end

  // Outputs are registered so they change only on the transmit clock rise.
  // A data underrun mid-frame is sent as an error nibble, not a gap.
  always_ff @(posedge port_tx_clock)
  begin
    if (!tx_resetn_i)
    begin
      port_tx_enable <= 1'b0;
      port_tx_error  <= 1'b0;
      port_tx_nibble <= 4'h0;
    end
    else
    begin
      case (state)
        TX_PREAMBLE:
        begin
          port_tx_enable <= !abort;
          port_tx_error  <= 1'b0;
          port_tx_nibble <= (pre_cnt == `PREAMBLE_NIBBLES) ?
                            `SFD_NIBBLE : `PREAMBLE_NIBBLE;
        end
        TX_DATA:
        begin
          port_tx_enable <= !abort;
          port_tx_error  <= !abort && (tx_corrupt_i || !tx_valid_i);
          port_tx_nibble <= tx_data_i;
        end
        default:
        begin
          port_tx_enable <= 1'b0;
          port_tx_error  <= 1'b0;
          port_tx_nibble <= 4'h0;
        end
      endcase
    end
  end

  always_ff @(posedge port_tx_clock)
  begin
    if (!tx_resetn_i)
      tx_act_tgl <= 1'b0;
    else if (port_tx_enable)
      tx_act_tgl <= ~tx_act_tgl;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Core side: LEDs and carrier status.

  logic rx_tgl_s;
  logic tx_tgl_s;
  logic rx_tgl_d;
  logic tx_tgl_d;
  logic link_s;
  logic [`ACT_CNT_W-1:0] act_cnt;

  sync_two_ff u_rx_act_sync
  (
    .clk_i    (clk_i),
    .resetn_i (resetn_i),
    .async_i  (rx_act_tgl),
    .sync_o   (rx_tgl_s)
  );

  sync_two_ff u_tx_act_sync
  (
    .clk_i    (clk_i),
    .resetn_i (resetn_i),
    .async_i  (tx_act_tgl),
    .sync_o   (tx_tgl_s)
  );

  sync_two_ff u_crs_core_sync
  (
    .clk_i    (clk_i),
    .resetn_i (resetn_i),
    .async_i  (port_carrier_sense),
    .sync_o   (carrier_o)
  );

  sync_two_ff u_link_sync
  (
    .clk_i    (clk_i),
    .resetn_i (resetn_i),
    .async_i  (link_up_i),
    .sync_o   (link_s)
  );

  // Several toggles may merge at the slower core clock; any change still
  // restarts the hold, which is all the LED needs.
  always_ff @(posedge clk_i)
  begin
    if (!resetn_i)
    begin
      rx_tgl_d <= 1'b0;
      tx_tgl_d <= 1'b0;
      act_cnt  <= '0;
    end
    else
    begin
      rx_tgl_d <= rx_tgl_s;
      tx_tgl_d <= tx_tgl_s;
      if ((rx_tgl_s != rx_tgl_d) || (tx_tgl_s != tx_tgl_d))
        act_cnt <= `ACT_CNT_W'(`ACT_HOLD_CYCLES);
      else if (act_cnt != '0)
        act_cnt <= act_cnt - `ACT_CNT_W'(1);
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (!resetn_i)
    begin
      port_link_led_n     <= 1'b1;
      port_activity_led_n <= 1'b1;
    end
    else
    begin
      port_link_led_n     <= !link_s;
      port_activity_led_n <= (act_cnt == '0);
    end
  end

endmodule // mii_port

`default_nettype wire

// file: tb/mii_port_monitor.sv
/* Checker on the pins of the MII port.
   Assumes the bind at the foot and free-running link clocks. */
`default_nettype none
module mii_port_monitor
  import mii_port_pkg::*;
(
  input wire logic    clk_i,              // Core.
  input wire logic    resetn_i,           // Core reset.
  input wire logic    port_rx_clock,      // Rx clock.
  input wire logic    port_tx_clock,      // Tx clock.
  input wire logic    rx_resetn_i,        // Rx reset.
  input wire logic    tx_resetn_i,        // Tx reset.
  input wire nibble_t port_rx_nibble,     // Rx pins.
  input wire logic    port_rx_valid,      // Rx valid.
  input wire logic    port_rx_error,      // Rx error.
  input wire logic    port_collision_in,  // Collision.
  input wire logic    port_tx_enable,     // Tx enable.
  input wire logic    port_tx_error,      // Tx error.
  input wire nibble_t port_tx_nibble,     // Tx pins.
  input wire logic    port_link_led_n,    // Link LED.
  input wire logic    link_up_i,          // Link.
  input wire logic    half_duplex_i,      // Duplex.
  input wire logic    tx_valid_i,         // Offer.
  input wire logic    rx_valid_o,         // Rx out.
  input wire nibble_t rx_data_o,          // Rx data.
  input wire logic    rx_frame_err_o,     // Frame error.
  input wire logic    rx_false_carrier_o  // False carrier.
);
  sequence s_pre;
    (port_tx_nibble == 4'h5) [*8] ##1 (port_tx_nibble == 4'h5) [*7];
  endsequence
  sequence s_sfd;
    port_tx_nibble == 4'hd;
  endsequence
  a_tx_preamble: assert property (@(posedge port_tx_clock)
    disable iff (!tx_resetn_i || half_duplex_i) $rose(port_tx_enable)
    |-> port_tx_enable throughout (s_pre ##1 s_sfd))
    else $error("bad preamble");
  a_start_cause: assert property (@(posedge port_tx_clock)
    disable iff (!tx_resetn_i) $rose(port_tx_enable) |-> $past(tx_valid_i, 2))
    else $error("frame without offer");
  a_err_in_frame: assert property (@(posedge port_tx_clock)
    disable iff (!tx_resetn_i) port_tx_error |-> port_tx_enable)
    else $error("tx error outside frame");
  a_collision_abort: assert property (@(posedge port_tx_clock)
    disable iff (!tx_resetn_i)
    (half_duplex_i && port_tx_enable && port_collision_in) [*2]
    |-> ##[1:3] !port_tx_enable)
    else $error("no abort");
  a_rx_data: assert property (@(posedge port_rx_clock)
    disable iff (!rx_resetn_i) port_rx_valid
    |-> ##2 rx_valid_o && rx_data_o == $past(port_rx_nibble, 2))
    else $error("rx data lost");
  a_rx_frame_err: assert property (@(posedge port_rx_clock)
    disable iff (!rx_resetn_i) port_rx_valid && port_rx_error
    |-> ##2 rx_frame_err_o && !rx_false_carrier_o)
    else $error("frame error missed");
  a_false_carrier: assert property (@(posedge port_rx_clock)
    disable iff (!rx_resetn_i)
    !port_rx_valid && port_rx_error && port_rx_nibble == 4'he
    |-> ##2 rx_false_carrier_o && !rx_frame_err_o)
    else $error("false carrier missed");
  a_link_led: assert property (@(posedge clk_i)
    disable iff (!resetn_i) $rose(link_up_i) |-> ##[1:4] !port_link_led_n)
    else $error("link LED late");
endmodule // mii_port_monitor

bind mii_port mii_port_monitor mon (.*);
`default_nettype wire

// file: tb/phy_model.sv
/* Behavioural PHY facing the MII port.
   Assumes the bench steers it by rx_cycle and coll_cmd. */
`default_nettype none
module phy_model
  import mii_port_pkg::*;
(
  output logic        port_rx_clock,      // Rx clock.
  output logic        port_tx_clock,      // Tx clock.
  output nibble_t     port_rx_nibble,     // Rx pins.
  output logic        port_rx_valid,      // Rx valid.
  output logic        port_rx_error,      // Rx error.
  output logic        port_collision_in,  // Collision.
  output logic        port_carrier_sense, // Carrier.
  input  wire logic   port_tx_enable,     // Tx enable.
  input  wire nibble_t port_tx_nibble,    // Tx pins.
  input  wire logic   port_tx_error       // Tx error.
);
  timeunit 1ns;
  timeprecision 100ps;
  nibble_t got[$];
  int      n_err;
  logic    coll_cmd;
  initial
  begin
    {port_tx_clock, port_rx_valid, port_rx_error, coll_cmd} = 4'h0;
    port_rx_nibble = 4'h0;
    n_err = 0;
    port_rx_clock = 1'b0;
    #4;
    forever #15 port_rx_clock = ~port_rx_clock;
  end
  always #15 port_tx_clock = ~port_tx_clock;
  always @(posedge port_tx_clock)
  begin
    if (port_tx_enable)
      got.push_back(port_tx_nibble);
    n_err += int'(port_tx_error && port_tx_enable);
  end
  assign port_carrier_sense = port_tx_enable | port_rx_valid;
  assign port_collision_in = coll_cmd & port_tx_enable;
  task automatic rx_cycle(input logic v, input logic e, input nibble_t d);
    @(posedge port_rx_clock);
    #2;
    port_rx_valid = v;
    port_rx_error = e;
    port_rx_nibble = d;
  endtask
endmodule // phy_model
`default_nettype wire

// file: tb/tb_second_port_mii_phy_link.sv
/* Bench for the second MII port.
   Assumes the PHY model and the bound checker. */
`default_nettype none
module tb_second_port_mii_phy_link;
  timeunit 1ns;
  timeprecision 100ps;
  import mii_port_pkg::*;
  logic clk_i, resetn_i, rx_resetn_i, tx_resetn_i, link_up_i;
  logic half_duplex_i, tx_valid_i, tx_last_i, tx_corrupt_i, abort_seen;
  logic port_rx_clock, port_tx_clock, port_rx_valid, port_rx_error;
  logic port_collision_in, port_carrier_sense, port_tx_enable;
  logic port_tx_error, port_link_led_n, port_activity_led_n, tx_ready_o;
  logic tx_abort_o, rx_valid_o, rx_frame_err_o, rx_false_carrier_o;
  logic carrier_o;
  nibble_t port_rx_nibble, port_tx_nibble, tx_data_i, rx_data_o;
  nibble_t rxq[$];
  int mismatches, n_compared, n_ferr, n_fc;
  mii_port dut (.*);
  phy_model phy (.*);
  always #50 clk_i = ~clk_i;
  // Outputs are read on the falling edge, where they have settled.
  always @(negedge port_rx_clock)
  begin
    if (rx_valid_o)
      rxq.push_back(rx_data_o);
    n_ferr += int'(rx_frame_err_o === 1'b1);
    n_fc += int'(rx_false_carrier_o === 1'b1);
  end
  always @(negedge port_tx_clock)
    if (tx_abort_o === 1'b1)
      abort_seen = 1'b1;
  //////////////////////////////////////////////////////////////////////////
  task chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task complete_run;
    $display("mismatches %0d compared %0d", mismatches, n_compared);
    if (mismatches == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task timeout;
    mismatches++;
    complete_run;
  endtask
  task test_led;
    @(posedge clk_i);
    #2;
    chk(port_activity_led_n, 1'b1);
    link_up_i = 1'b1;
    repeat (5) @(posedge clk_i);
    chk(port_link_led_n, 1'b0);
    link_up_i = 1'b0;
    repeat (5) @(posedge clk_i);
    chk(port_link_led_n, 1'b1);
  endtask
  task test_rx;
    for (int i = 0; i < 8; i++)
      phy.rx_cycle(1'b1, i == 5, nibble_t'(i + 1));
    phy.rx_cycle(1'b0, 1'b1, 4'he);
    phy.rx_cycle(1'b0, 1'b0, 4'h1);
    repeat (4) @(posedge port_rx_clock);
    chk(8'(rxq.size()), 8'h08);
    foreach (rxq[i]) chk(rxq[i], 8'(i + 1));
    chk(8'(n_ferr), 8'h01);
    chk(8'(n_fc), 8'h01);
  endtask
  task test_tx;
    int k, t;
    k = 0;
    t = 0;
    @(posedge port_tx_clock);
    #2;
    tx_valid_i = 1'b1;
    while (k < 3)
    begin
      tx_data_i = nibble_t'(k + 10);
      tx_last_i = (k == 2);
      tx_corrupt_i = (k == 1);
      @(negedge port_tx_clock);
      if (tx_ready_o === 1'b1)
        k++;
      @(posedge port_tx_clock);
      #2;
      if (++t > 60)
        timeout;
    end
    {tx_valid_i, tx_last_i, tx_corrupt_i} = 3'h0;
    chk(carrier_o, 1'b1);
    repeat (4) @(posedge clk_i);
    chk(carrier_o, 1'b0);
    chk(8'(phy.got.size()), 8'h13);
    for (int i = 0; i < 15; i++) chk(phy.got[i], 8'h05);
    chk(phy.got[15], 8'h0d);
    for (int i = 0; i < 3; i++) chk(phy.got[16 + i], 8'(i + 10));
    chk(8'(phy.n_err), 8'h01);
    chk(port_tx_enable, 1'b0);
    chk(port_activity_led_n, 1'b0);
  endtask
  task test_coll;
    int t;
    half_duplex_i = 1'b1;
    @(posedge port_tx_clock);
    #2;
    {tx_valid_i, tx_last_i, tx_data_i} = 6'h31;
    repeat (4) @(posedge port_tx_clock);
    #2;
    phy.coll_cmd = 1'b1;
    t = 0;
    while (port_tx_enable !== 1'b0)
    begin
      @(posedge port_tx_clock);
      #2;
      if (++t > 8)
        timeout;
    end
    {phy.coll_cmd, tx_valid_i, tx_last_i} = 3'h0;
    chk(abort_seen, 1'b1);
    repeat (2) @(posedge port_tx_clock);
    half_duplex_i = 1'b0;
  endtask
  initial
  begin
    {clk_i, resetn_i, rx_resetn_i, tx_resetn_i, link_up_i} = 5'h0;
    {half_duplex_i, tx_valid_i, tx_last_i, tx_corrupt_i} = 4'h0;
    {tx_data_i, abort_seen} = 5'h0;
    {mismatches, n_compared, n_ferr, n_fc} = '0;
    repeat (10) @(posedge clk_i);
    #2;
    {resetn_i, rx_resetn_i, tx_resetn_i} = 3'h7;
    test_led;
    test_rx;
    test_tx;
    test_coll;
    complete_run;
  end
endmodule // tb_second_port_mii_phy_link
`default_nettype wire
